/* File: test/rx_mac_model.sv */
// receive mac stand-in driving octet increments
// assumes callers pass whole bursts
`default_nettype none
module rx_mac_model (
    // clock
    input wire logic core_clk,
    // increments
    output logic [15:0] good_octet_increment,
    output logic good_octet_increment_strobe
);
    timeunit 1ns;
    timeprecision 100ps;
    initial good_octet_increment = 16'h0000;
    initial good_octet_increment_strobe = 1'b0;
    task automatic burst(input int n, input logic [15:0] v, input logic slow);
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            good_octet_increment_strobe <= 1'b1;
            good_octet_increment <= v;
            if (slow) begin
                @(posedge core_clk);
                good_octet_increment_strobe <= 1'b0;
                good_octet_increment <= ~v;
            end
        end
        @(posedge core_clk);
        good_octet_increment_strobe <= 1'b0;
        good_octet_increment <= ~v;
    endtask
endmodule
`default_nettype wire

/* File: test/rx_stats_monitor.sv */
// checker for the statistics bank port
// assumes a bind into the bank, ports only
`default_nettype none
module rx_stats_monitor
    import rx_stats_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W+ADDR_LSB-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // increments and interrupt
    input wire logic [INC_W-1:0] good_octet_increment,
    input wire logic good_octet_increment_strobe,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****
    // request tracking
    // ****
    logic [11:0] idx_q;
    logic rd_q;
    logic shadow_q;
    wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic rdack = wb_ack_o && rd_q;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            idx_q <= 12'h000;
            rd_q <= 1'b0;
            shadow_q <= 1'b0;
        end else if (take) begin
            idx_q <= wb_adr_i[13:2];
            rd_q <= !wb_we_i;
            if (wb_we_i && wb_sel_i[0] && wb_adr_i[13:2] == IDX_CONTROL) begin
                shadow_q <= wb_dat_i[CTL_SHADOW];
            end
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    property p_ack_next; take |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
    property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == ZERO_WORD; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("data not idle");
    property p_ctl; rdack && idx_q == IDX_CONTROL |-> (wb_dat_o & 32'hffff_fffb) == 0; endproperty
    a_ctl: assert property (p_ctl) else $error("control bits");
    property p_paused; rdack && idx_q == IDX_STATE |-> wb_dat_o[31:1] == {30'h0, shadow_q};
    endproperty
    a_paused: assert property (p_paused) else $error("paused bit");
    property p_ident; rdack && idx_q == IDX_IDENT_FIRST |-> wb_dat_o == IDENT_FIRST; endproperty
    a_ident: assert property (p_ident) else $error("ident word");
    property p_rev; rdack && idx_q == IDX_REVISION |-> wb_dat_o == REVISION_ID; endproperty
    a_rev: assert property (p_rev) else $error("revision word");
    property p_unmapped; rdack && idx_q == 12'h947 |-> wb_dat_o == ZERO_WORD; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    c_paused: cover property (rdack && idx_q == IDX_STATE && wb_dat_o[ST_PAUSED]);
    c_ctl_wr: cover property (wb_ack_o && !rd_q && idx_q == IDX_CONTROL);
    c_unmapped: cover property (rdack && idx_q == 12'h947);
endmodule
bind rx_statistics_control_bank rx_stats_monitor i_mon (.*);
`default_nettype wire

/* File: test/testbench.sv */
// register walk of the statistics bank
// assumes the mac model feeds the increments
`default_nettype none
module testbench
    import rx_stats_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [13:0] adr = 14'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [63:0] cnt = 64'h0;
    wire logic [31:0] dat_o;
    wire logic [15:0] inc;
    wire logic ack, irq, strobe;
    int failures = 0, total_checks = 0;
    always #12.5 core_clk = ~core_clk;
    rx_statistics_control_bank i_dut (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .good_octet_increment(inc),
        .good_octet_increment_strobe(strobe), .irq(irq));
    rx_mac_model i_mac (.core_clk(core_clk), .good_octet_increment(inc),
        .good_octet_increment_strobe(strobe));
    // ****
    // tasks
    // ****
    task automatic final_report();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [11:0] i, input logic w, input logic [31:0] d,
        output logic [31:0] q);
        int k;
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        sel <= 4'hf;
        dat <= d;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        q = dat_o;
        if (k >= 20) begin
            failures++;
            final_report();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
    endtask
    task automatic wr(input logic [11:0] i, input logic [31:0] d);
        logic [31:0] q;
        bus(i, 1'b1, d, q);
    endtask
    task automatic rd(input logic [11:0] i, input logic [31:0] exp);
        logic [31:0] q;
        bus(i, 1'b0, 32'h0, q);
        check(q, exp);
    endtask
    task automatic feed(input int n, input logic [15:0] v, input logic slow);
        i_mac.burst(n, v, slow);
        repeat (n) cnt += 64'(v);
    endtask
    initial begin
        logic [63:0] snap;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(IDX_SCRATCH, SCRATCH_RESET);
        rd(IDX_REVISION, REVISION_ID);
        wr(IDX_IDENT_FIRST, 32'h0);
        rd(IDX_IDENT_FIRST, IDENT_FIRST);
        rd(IDX_IDENT_NEXT, IDENT_NEXT);
        rd(IDX_IDENT_FINAL, IDENT_FINAL);
        rd(IDX_STATE, ZERO_WORD);
        wr(IDX_SCRATCH, 32'ha5c3_3c5a);
        rd(IDX_SCRATCH, 32'ha5c3_3c5a);
        wr(12'h947, 32'hffff_ffff);
        rd(12'h947, ZERO_WORD);
        feed(3, 16'hffff, 1'b0);
        feed(2, 16'h0010, 1'b1);
        rd(IDX_OCTETS_LOW, cnt[31:0]);
        rd(IDX_OCTETS_HIGH, cnt[63:32]);
        wr(IDX_CONTROL, 32'h4);
        snap = cnt;
        feed(4, 16'h1234, 1'b0);
        rd(IDX_STATE, 32'h2);
        rd(IDX_OCTETS_LOW, snap[31:0]);
        wr(IDX_CONTROL, 32'h0);
        rd(IDX_OCTETS_LOW, cnt[31:0]);
        wr(IDX_CONTROL, 32'hffff_fff9);
        cnt = 64'h0;
        rd(IDX_CONTROL, ZERO_WORD);
        rd(IDX_OCTETS_LOW, ZERO_WORD);
        wr(IDX_CONTROL, 32'h2);
        rd(IDX_STATE, ZERO_WORD);
        rd(IDX_IRQ_MASK, ZERO_WORD);
        wr(IDX_IRQ_MASK, 32'h3);
        rd(IDX_IRQ_MASK, 32'h3);
        check({31'h0, irq}, ZERO_WORD);
        final_report();
    end
endmodule
`default_nettype wire

/* File: verilog/rx_statistics_control_bank.sv */
// receive statistics control and status register bank with good-octet counter
// assumes synchronous increment inputs and a classic wishbone master on core_clk
//
// Operation
// - A 32-bit scratch register reads back what was written and resets to 0x09.
// - Three read-only identifier words give the variant string in first, next, final order.
// - While shadow request is set, reads return a frozen snapshot while counters keep counting.
// - Writing one to parity clear clears the parity flag and the bit returns to zero itself.
// - Writing one to reset-all clears every statistics count at once and self-clears.
// - Only control bits 2..0 exist; bits 31..3 are reserved.
// - Paused status reads one exactly while shadow request is set.
// - Parity status reads one once any counter parity error is seen; bits 31..2 reserved.
// - A 64-bit good-octet count is read as a low word and a high word.
// - Each cycle with the strobe high adds the 16-bit increment to the good-octet count, except the cycle in which reset-all clears it.
// - A read-only revision word sits just below the scratch register.
//
// Design decision made here: register access over Wishbone.
`default_nettype none
module rx_statistics_control_bank
    import rx_stats_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W+ADDR_LSB-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // receive mac increments
    input wire logic [INC_W-1:0] good_octet_increment,
    input wire logic good_octet_increment_strobe,
    // interrupt
    output logic irq
);

    typedef struct packed {
        logic [31:0] scratch;
        logic [CTL_W-1:0] control;
        logic parity_err;
        logic [63:0] octets;
        logic octets_par;
        logic [63:0] snapshot;
        logic [EV_W-1:0] irq_status;
        logic [EV_W-1:0] irq_mask;
        logic [31:0] dat;
        logic ack;
        logic irq;
    } state_t;

    state_t s_reg;
    state_t s_next;

    logic req;
    logic wr;
    logic [ADDR_W-1:0] idx;
    logic [31:0] wmask;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [63:0] visible;
    logic [63:0] sum;
    logic wrap;
    logic par_bad;
    logic [EV_W-1:0] events;

    // ********************************
    // bus decode
    // ********************************
    assign req = wb_cyc_i & wb_stb_i & ~s_reg.ack;
    assign wr = req & wb_we_i;
    assign idx = wb_adr_i[ADDR_W+ADDR_LSB-1:ADDR_LSB];
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wdata = wb_dat_i & wmask;

    assign visible = s_reg.control[CTL_SHADOW] ? s_reg.snapshot : s_reg.octets;

    // ********************************
    // read mux
    // ********************************
    always_comb begin
        case (idx)
            IDX_REVISION: rdata = REVISION_ID;
            IDX_SCRATCH: rdata = s_reg.scratch;
            IDX_IDENT_FIRST: rdata = IDENT_FIRST;
            IDX_IDENT_NEXT: rdata = IDENT_NEXT;
            IDX_IDENT_FINAL: rdata = IDENT_FINAL;
            IDX_CONTROL: rdata = {29'h0, s_reg.control};
            IDX_STATE: rdata = {30'h0, s_reg.control[CTL_SHADOW], s_reg.parity_err};
            IDX_IRQ_STATUS: rdata = {30'h0, s_reg.irq_status};
            IDX_IRQ_MASK: rdata = {30'h0, s_reg.irq_mask};
            IDX_OCTETS_LOW: rdata = visible[31:0];
            IDX_OCTETS_HIGH: rdata = visible[63:32];
            default: rdata = ZERO_WORD;
        endcase
    end

    // ********************************
    // counter arithmetic
    // ********************************
    // add increment on strobe
    assign sum = s_reg.octets + {48'h0, good_octet_increment};
    assign wrap = good_octet_increment_strobe & (sum < s_reg.octets);
    // parity of the stored count checked against its kept parity bit
    assign par_bad = (^s_reg.octets) != s_reg.octets_par;

    always_comb begin
        s_next = s_reg;
        events = '0;
        s_next.ack = req;
        s_next.dat = req ? rdata : ZERO_WORD;

        s_next.control[CTL_PARITY_CLR] = 1'b0;
        s_next.control[CTL_RESET_ALL] = 1'b0;

        if (good_octet_increment_strobe) begin
            s_next.octets = sum;
            s_next.octets_par = ^sum;
        end

        if (s_reg.control[CTL_RESET_ALL]) begin
            s_next.octets = ZERO_COUNT;
            s_next.octets_par = 1'b0;
            s_next.snapshot = ZERO_COUNT;
        end

        if (s_reg.control[CTL_PARITY_CLR] | s_reg.control[CTL_RESET_ALL]) begin
            s_next.parity_err = 1'b0;
        end
        if (par_bad) begin
            s_next.parity_err = 1'b1;
        end
        events[EV_PARITY] = par_bad & ~s_reg.parity_err;
        events[EV_WRAP] = wrap;

        if (wr) begin
            case (idx)
                IDX_SCRATCH: s_next.scratch = (s_reg.scratch & ~wmask) | wdata;
                IDX_CONTROL: begin
                    if (wb_sel_i[0]) begin
                        s_next.control = wb_dat_i[CTL_W-1:0];
                        if (wb_dat_i[CTL_SHADOW] & ~s_reg.control[CTL_SHADOW]) begin
                            s_next.snapshot = s_reg.octets;
                        end
                    end
                end
                IDX_IRQ_STATUS: begin
                    if (wb_sel_i[0]) begin
                        s_next.irq_status = s_reg.irq_status & ~wb_dat_i[EV_W-1:0];
                    end
                end
                IDX_IRQ_MASK: begin
                    if (wb_sel_i[0]) begin
                        s_next.irq_mask = wb_dat_i[EV_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // events win over clears
        s_next.irq_status = s_next.irq_status | events;
        s_next.irq = |(s_next.irq_status & s_next.irq_mask);
    end

    // ********************************
    // state register
    // ********************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
            s_reg.scratch <= SCRATCH_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign wb_dat_o = s_reg.dat;
    assign wb_ack_o = s_reg.ack;
    assign irq = s_reg.irq;

endmodule
`default_nettype wire

/* File: verilog/rx_stats_pkg.sv */
// constants for the receive statistics register bank
// assumes a 32-bit classic wishbone slave with word index addressing (byte addr = 4*index)
`default_nettype none
package rx_stats_pkg;
    // register indices
    localparam logic [11:0] IDX_REVISION = 12'h940;
    localparam logic [11:0] IDX_SCRATCH = 12'h941;
    localparam logic [11:0] IDX_IDENT_FIRST = 12'h942;
    localparam logic [11:0] IDX_IDENT_NEXT = 12'h943;
    localparam logic [11:0] IDX_IDENT_FINAL = 12'h944;
    localparam logic [11:0] IDX_CONTROL = 12'h945;
    localparam logic [11:0] IDX_STATE = 12'h946;
    localparam logic [11:0] IDX_IRQ_STATUS = 12'h950;
    localparam logic [11:0] IDX_IRQ_MASK = 12'h951;
    localparam logic [11:0] IDX_OCTETS_LOW = 12'h960;
    localparam logic [11:0] IDX_OCTETS_HIGH = 12'h961;
    localparam int ADDR_LSB = 2;
    localparam int ADDR_W = 12;

    // reset values
    localparam logic [31:0] SCRATCH_RESET = 32'h0000_0009;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [63:0] ZERO_COUNT = 64'h0;

    // control field positions
    localparam int CTL_RESET_ALL = 0;
    localparam int CTL_PARITY_CLR = 1;
    localparam int CTL_SHADOW = 2;
    localparam int CTL_W = 3;
    // state field positions
    localparam int ST_PARITY = 0;
    localparam int ST_PAUSED = 1;
    localparam int ST_W = 2;
    // interrupt events: parity raised, counter wrapped
    localparam int EV_PARITY = 0;
    localparam int EV_WRAP = 1;
    localparam int EV_W = 2;

    // identity words, arbitrary neutral values
    localparam logic [31:0] REVISION_ID = 32'h0000_0001;
    localparam logic [31:0] IDENT_FIRST = 32'h7878_7878;
    localparam logic [31:0] IDENT_NEXT = 32'h7979_7979;
    localparam logic [31:0] IDENT_FINAL = 32'h7a7a_7a7a;

    localparam int INC_W = 16;
    localparam int PAR_W = 64;
endpackage
`default_nettype wire
